/* scjmp_bus_model.sv */
module scjmp_bus_model (
    input  wire logic             clk_i,
    output scjmp_pkg::scjmp_bus_t bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import scjmp_pkg::*;
    time req_t;
    initial bus_o = '0;

    // A phase is shown with busy asserted and select driven as given.
    task automatic enter(input logic [2:0] ph, input logic sl, input logic at);
        @(posedge clk_i);
        bus_o.phase <= ph;
        bus_o.sel   <= sl;
        bus_o.bsy   <= 1'b1;
        bus_o.atn   <= at;
        bus_o.req   <= 1'b0;
    endtask : enter

    // Request follows the phase after a chosen delay, prompt or slow.
    task automatic req_on(input int dly);
        repeat (dly) @(posedge clk_i);
        @(posedge clk_i);
        bus_o.req <= ~bus_o.sel;
        req_t = $time;
    endtask : req_on
endmodule : scjmp_bus_model

/* scjmp_cond.sv */
module scjmp_cond (
    input  wire logic                    target_mode_i,
    input  wire scjmp_pkg::scjmp_instr_t instr_i,
    input  wire scjmp_pkg::scjmp_bus_t   bus_i,
    input  wire logic [7:0]              fbr_i,
    input  wire logic                    carry_i,
    output logic                         cond_o
);
    import scjmp_pkg::*;

    // ---------------------------------------------------------------
    // Condition evaluation
    // ---------------------------------------------------------------
    wire phase_valid = !bus_i.sel && bus_i.bsy;
    wire phase_eq    = phase_valid && (bus_i.phase == instr_i.phase);
    wire phase_res   = target_mode_i ? bus_i.atn : phase_eq;
    wire phase_term  = instr_i.cmp_phase ? phase_res : 1'b1;
    wire data_eq     = ((fbr_i ^ instr_i.data) & ~instr_i.mask) == 8'h00;
    wire data_term   = instr_i.cmp_data ? data_eq : 1'b1;

    // Carry test overrides both comparisons.
    assign cond_o = instr_i.carry_test ? carry_i
                                       : (phase_term && data_term);

endmodule : scjmp_cond

/* scjmp_pkg.sv */
package scjmp_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CMD     = 8'h00;
    localparam logic [7:0] OFS_BCF     = 8'h04;
    localparam logic [7:0] OFS_DEST    = 8'h08;
    localparam logic [7:0] OFS_PC      = 8'h0C;
    localparam logic [7:0] OFS_FBR     = 8'h10;
    localparam logic [7:0] OFS_CTRL    = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;

    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_TARGET_BIT = 1;

    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_TAKEN_BIT  = 1;
    localparam int STAT_DONE_BIT   = 2;
    localparam int STAT_ERROR_BIT  = 3;

    localparam logic [7:0]  RST_CMD  = 8'h00;
    localparam logic [23:0] RST_BCF  = 24'h00_0000;
    localparam logic [31:0] RST_DEST = 32'h0000_0000;
    localparam logic [31:0] RST_PC   = 32'h0000_0000;
    localparam logic [7:0]  RST_FBR  = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // Instruction encoding
    // ---------------------------------------------------------------
    localparam logic [1:0] ITYPE_XFER_CTRL = 2'h2;
    localparam logic [2:0] OPC_JUMP        = 3'h0;
    localparam int         REL_OFS_W       = 24;

    // Phase codes as message, command/data, input/output.
    localparam logic [2:0] PH_DATA_OUT = 3'h0;
    localparam logic [2:0] PH_DATA_IN  = 3'h1;
    localparam logic [2:0] PH_COMMAND  = 3'h2;
    localparam logic [2:0] PH_STATUS   = 3'h3;
    localparam logic [2:0] PH_RES4     = 3'h4;
    localparam logic [2:0] PH_RES5     = 3'h5;
    localparam logic [2:0] PH_MSG_OUT  = 3'h6;
    localparam logic [2:0] PH_MSG_IN   = 3'h7;

    typedef struct packed {
        logic [1:0] itype;
        logic [2:0] opcode;
        logic [2:0] phase;
        logic       rel_addr;
        logic       rsvd22;
        logic       carry_test;
        logic       rsvd20;
        logic       true_bit;
        logic       cmp_data;
        logic       cmp_phase;
        logic       wait_bit;
        logic [7:0] mask;
        logic [7:0] data;
    } scjmp_instr_t;

    // Bus lines in asserted-high sense.
    typedef struct packed {
        logic [2:0] phase;
        logic       sel;
        logic       bsy;
        logic       req;
        logic       atn;
    } scjmp_bus_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_EXEC = 2'b11
    } scjmp_state_t;

endpackage : scjmp_pkg

/* scjmp_props.sv */
module scjmp_props (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_I,
    input wire logic        S_AXI_AWVALID_I,
    input wire logic        S_AXI_AWREADY_O,
    input wire logic        S_AXI_WVALID_I,
    input wire logic        S_AXI_WREADY_O,
    input wire logic [1:0]  S_AXI_BRESP_O,
    input wire logic        S_AXI_BVALID_O,
    input wire logic        S_AXI_BREADY_I,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0]  S_AXI_RRESP_O,
    input wire logic        S_AXI_RVALID_O,
    input wire logic [31:0] PC_O,
    input wire logic        FETCH_O,
    input wire logic        TAKEN_O,
    input wire logic        BUSY_O
);
    timeunit 1ns;
    timeprecision 1ns;
    import scjmp_pkg::*;
    // ---------------------------------------------------------------
    // Sequencer and register bus properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    a_taken_with_fetch: assert property (TAKEN_O |-> FETCH_O)
        else $error("taken flagged without a fetch");
    a_fetch_one_cycle: assert property (FETCH_O |=> !FETCH_O)
        else $error("fetch pulse longer than one cycle");
    a_pc_kept_fallthru: assert property (FETCH_O && !TAKEN_O |-> PC_O == $past(PC_O))
        else $error("pointer moved on a jump not taken");
    a_fetch_ends_busy: assert property (FETCH_O |-> !BUSY_O && $past(BUSY_O))
        else $error("fetch not at the end of a busy spell");
    a_idle_gives_fetch: assert property ($fell(BUSY_O) |-> FETCH_O)
        else $error("sequencer went idle without a fetch");
    a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O)
        else $error("write response late");
    a_bresp_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
        S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped early");
    a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read response late");
    a_read_blocked: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read address taken while answering");
    a_unmapped_zero: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR
        |-> S_AXI_RDATA_O == 32'h0000_0000)
        else $error("error read returned data");

    c_taken: cover property (TAKEN_O);
    c_fallthru: cover property (FETCH_O && !TAKEN_O);
    c_slverr: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_SLVERR);
endmodule : scjmp_props

/* scjmp_tb_top.sv */
module scjmp_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import scjmp_pkg::*;
    localparam logic [7:0]  F_REL = 8'h80, F_CAR = 8'h20, F_TRU = 8'h08;
    localparam logic [7:0]  F_CD = 8'h04, F_CP = 8'h02, F_WT = 8'h01;
    localparam logic [31:0] PC0 = 32'h0000_0100, DST = 32'h0000_2000;
    logic clk, rst, awv, wv, bry, arv, rry, fl, cy, awr, wr, bv, arr, rv;
    logic fetch, taken, busy, last_tk;
    logic [7:0] awa, ara, fd;
    logic [31:0] wd, rd, pc, last_pc, d;
    logic [1:0] br, rr, r;
    scjmp_bus_t bus;
    int n_fail, n_checks, n_fetch;
    time fetch_t;

    scjmp_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
        .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rry), .BUS_I(bus), .FBR_LOAD_I(fl), .FBR_DATA_I(fd),
        .ALU_CARRY_I(cy), .PC_O(pc), .FETCH_O(fetch), .TAKEN_O(taken), .BUSY_O(busy));
    scjmp_bus_model i_bus (.clk_i(clk), .bus_o(bus));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (fetch === 1'b1) begin
            n_fetch <= n_fetch + 1;
            last_tk <= taken;
            last_pc <= pc;
            fetch_t <= $time;
        end
    end
    // ---------------------------------------------------------------
    // Bus tasks and comparisons
    // ---------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        awa <= a;
        wd  <= v;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!(bv === 1'b1) && n < 50);
        rs = br;
        chk_val({31'h0, bv}, 32'h0000_0001);
        bry <= 1'b0;
        @(posedge clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'b0;
        end while (!(rv === 1'b1) && n < 50);
        v = rd;
        rs = rr;
        chk_val({31'h0, rv}, 32'h0000_0001);
        rry <= 1'b0;
        @(posedge clk);
    endtask : axi_rd
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_val({30'h0, got}, {30'h0, exp});
    endtask : chk_resp
    function automatic logic [31:0] mk(input logic [2:0] ph, input logic [7:0] f,
                                       input logic [7:0] m, input logic [7:0] v);
        return {ITYPE_XFER_CTRL, OPC_JUMP, ph, f, m, v};
    endfunction : mk
    task automatic run(input logic [31:0] w, input logic [31:0] dst, input logic tm,
                       input logic et, input logic [31:0] ep);
        int k;
        int n0;
        axi_wr(OFS_CMD, {24'h00_0000, w[31:24]}, r);
        axi_wr(OFS_BCF, {8'h00, w[23:0]}, r);
        axi_wr(OFS_DEST, dst, r);
        axi_wr(OFS_PC, PC0, r);
        n0 = n_fetch;
        axi_wr(OFS_CTRL, {30'h0, tm, 1'b1}, r);
        k = 0;
        while (n_fetch == n0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        chk_val({30'h0, n_fetch != n0, busy}, 32'h0000_0002);
        chk_val({31'h0, last_tk}, {31'h0, et});
        chk_val(last_pc, ep);
        axi_rd(OFS_STATUS, d, r);
        chk_val({28'h0, d[3:0] & 4'h6}, {29'h0, 1'b1, et, 1'b0});
    endtask : run
    task automatic load(input logic [7:0] v);
        @(posedge clk);
        fl <= 1'b1;
        fd <= v;
        @(posedge clk);
        fl <= 1'b0;
    endtask : load
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        {awv, wv, bry, arv, rry, fl, cy} = '0;
        {awa, ara, fd, wd} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            axi_rd(8'(i * 4), d, r);
            chk_val(d, 32'h0000_0000);
            chk_resp(r, RESP_OKAY);
        end
        axi_rd(8'h1C, d, r);
        chk_resp(r, RESP_SLVERR);
        axi_wr(8'h1C, 32'hFFFF_FFFF, r);
        chk_resp(r, RESP_SLVERR);
        $display("test registers done");
        run(mk(3'h0, F_TRU, 8'h00, 8'h00), DST, 1'b0, 1'b1, DST);
        run(mk(3'h0, 8'h00, 8'h00, 8'h00), DST, 1'b0, 1'b0, PC0);
        for (int p = 0; p < 8; p++) begin
            i_bus.enter(3'(p), 1'b0, 1'b0);
            i_bus.req_on(0);
            run(mk(3'(p), F_TRU | F_CP | F_WT, 8'h00, 8'h00), DST, 1'b0, 1'b1, DST);
            run(mk(3'(p) ^ 3'h1, F_TRU | F_CP | F_WT, 8'h00, 8'h00), DST, 1'b0, 1'b0, PC0);
            run(mk(3'(p) ^ 3'h4, F_CP | F_WT, 8'h00, 8'h00), DST, 1'b0, 1'b1, DST);
        end
        i_bus.enter(PH_STATUS, 1'b1, 1'b0);
        run(mk(PH_STATUS, F_TRU | F_CP, 8'h00, 8'h00), DST, 1'b0, 1'b0, PC0);
        $display("test phase done");
        load(8'hA5);
        run(mk(3'h0, F_TRU | F_CD, 8'h20, 8'h85), DST, 1'b0, 1'b1, DST);
        run(mk(3'h0, F_TRU | F_CD, 8'h00, 8'h85), DST, 1'b0, 1'b0, PC0);
        load(8'h85);
        run(mk(3'h0, F_TRU | F_CD, 8'h00, 8'h85), DST, 1'b0, 1'b1, DST);
        axi_rd(OFS_FBR, d, r);
        chk_val(d, 32'h0000_0085);
        i_bus.enter(PH_COMMAND, 1'b0, 1'b0);
        run(mk(PH_DATA_IN, F_TRU | F_CP | F_CD, 8'h00, 8'h85), DST, 1'b0, 1'b0, PC0);
        run(mk(PH_COMMAND, F_TRU | F_CP | F_CD, 8'h00, 8'h84), DST, 1'b0, 1'b0, PC0);
        run(mk(PH_COMMAND, F_TRU | F_CP | F_CD, 8'h00, 8'h85), DST, 1'b0, 1'b1, DST);
        $display("test data done");
        @(posedge clk);
        cy <= 1'b1;
        run(mk(PH_DATA_IN, F_TRU | F_CAR | F_CP | F_CD, 8'h00, 8'h00), DST, 1'b0, 1'b1, DST);
        @(posedge clk);
        cy <= 1'b0;
        run(mk(PH_COMMAND, F_TRU | F_CAR | F_CP | F_CD, 8'h00, 8'h85), DST, 1'b0, 1'b0, PC0);
        run(mk(3'h0, F_TRU | F_REL, 8'h00, 8'h00), 32'h00FF_FFF0, 1'b0, 1'b1, 32'h0000_00F0);
        run(mk(3'h0, F_TRU | F_REL, 8'h00, 8'h00), 32'h0000_0020, 1'b0, 1'b1, 32'h0000_0120);
        $display("test carry and relative done");
        i_bus.enter(PH_DATA_OUT, 1'b0, 1'b1);
        run(mk(PH_MSG_IN, F_TRU | F_CP, 8'h00, 8'h00), DST, 1'b1, 1'b1, DST);
        i_bus.enter(PH_DATA_OUT, 1'b0, 1'b0);
        run(mk(PH_DATA_OUT, F_TRU | F_CP, 8'h00, 8'h00), DST, 1'b1, 1'b0, PC0);
        i_bus.enter(PH_MSG_IN, 1'b0, 1'b0);
        fork
            run(mk(PH_MSG_IN, F_TRU | F_CP | F_WT, 8'h00, 8'h00), DST, 1'b0, 1'b1, DST);
            i_bus.req_on(60);
        join
        chk_val({31'h0, fetch_t > i_bus.req_t}, 32'h0000_0001);
        run({2'b01, 30'h0000_0008}, DST, 1'b0, 1'b0, PC0);
        axi_rd(OFS_STATUS, d, r);
        chk_val({31'h0, d[STAT_ERROR_BIT]}, 32'h0000_0001);
        $display("test target wait and decode done");
        report_and_stop();
    end
    initial begin
        #400_000;
        n_fail++;
        report_and_stop();
    end
endmodule : scjmp_tb_top

bind scjmp_top scjmp_props i_props (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .PC_O(PC_O),
    .FETCH_O(FETCH_O), .TAKEN_O(TAKEN_O), .BUSY_O(BUSY_O));

/* scjmp_top.sv */
module scjmp_top (
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RST_I,
    input  wire logic [7:0]            S_AXI_AWADDR_I,
    input  wire logic                  S_AXI_AWVALID_I,
    output logic                       S_AXI_AWREADY_O,
    input  wire logic [31:0]           S_AXI_WDATA_I,
    input  wire logic [3:0]            S_AXI_WSTRB_I,
    input  wire logic                  S_AXI_WVALID_I,
    output logic                       S_AXI_WREADY_O,
    output logic [1:0]                 S_AXI_BRESP_O,
    output logic                       S_AXI_BVALID_O,
    input  wire logic                  S_AXI_BREADY_I,
    input  wire logic [7:0]            S_AXI_ARADDR_I,
    input  wire logic                  S_AXI_ARVALID_I,
    output logic                       S_AXI_ARREADY_O,
    output logic [31:0]                S_AXI_RDATA_O,
    output logic [1:0]                 S_AXI_RRESP_O,
    output logic                       S_AXI_RVALID_O,
    input  wire logic                  S_AXI_RREADY_I,
    input  wire scjmp_pkg::scjmp_bus_t BUS_I,
    input  wire logic                  FBR_LOAD_I,
    input  wire logic [7:0]            FBR_DATA_I,
    input  wire logic                  ALU_CARRY_I,
    output logic [31:0]                PC_O,
    output logic                       FETCH_O,
    output logic                       TAKEN_O,
    output logic                       BUSY_O
);
    import scjmp_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    scjmp_state_t state_reg;
    scjmp_state_t state_next;
    scjmp_bus_t   bus_s1_reg;
    scjmp_bus_t   bus_s2_reg;
    scjmp_instr_t instr;

    logic [7:0]  cmd_reg;
    logic [23:0] bcf_reg;
    logic [31:0] dest_reg;
    logic [31:0] pc_reg;
    logic [7:0]  fbr_reg;
    logic        target_reg;
    logic        taken_reg;
    logic        done_reg;
    logic        error_reg;
    logic        fetch_reg;
    logic        taken_pulse_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        cond;

    // ---------------------------------------------------------------
    // Bus pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            bus_s1_reg <= '0;
            bus_s2_reg <= '0;
        end else begin
            bus_s1_reg <= BUS_I;
            bus_s2_reg <= bus_s1_reg;
        end
    end

    // ---------------------------------------------------------------
    // Instruction decode
    // ---------------------------------------------------------------
    assign instr = scjmp_instr_t'({cmd_reg, bcf_reg});
    wire is_jump     = (instr.itype == ITYPE_XFER_CTRL) && (instr.opcode == OPC_JUMP);
    wire phase_valid = !bus_s2_reg.sel && bus_s2_reg.bsy;
    wire req_ready   = bus_s2_reg.req && phase_valid;
    wire take_jump   = (cond == instr.true_bit);
    wire [31:0] rel_ofs = {{(32 - REL_OFS_W){dest_reg[REL_OFS_W - 1]}},
                           dest_reg[REL_OFS_W - 1:0]};
    wire [31:0] rel_dest = pc_reg + rel_ofs;
    wire [31:0] jump_dest = instr.rel_addr ? rel_dest : dest_reg;

    scjmp_cond u_cond (
        .target_mode_i (target_reg),
        .instr_i       (instr),
        .bus_i         (bus_s2_reg),
        .fbr_i         (fbr_reg),
        .carry_i       (ALU_CARRY_I),
        .cond_o        (cond)
    );

    // ---------------------------------------------------------------
    // AXI4-Lite write path
    // ---------------------------------------------------------------
    wire aw_fire = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    wire w_fire  = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire wr_go   = aw_held_reg && w_held_reg && !bvalid_reg;

    assign S_AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY_O  = !w_held_reg && !bvalid_reg;

    wire wr_cmd    = wr_go && (aw_addr_reg == OFS_CMD);
    wire wr_bcf    = wr_go && (aw_addr_reg == OFS_BCF);
    wire wr_dest   = wr_go && (aw_addr_reg == OFS_DEST);
    wire wr_pc     = wr_go && (aw_addr_reg == OFS_PC);
    wire wr_fbr    = wr_go && (aw_addr_reg == OFS_FBR);
    wire wr_ctrl   = wr_go && (aw_addr_reg == OFS_CTRL);
    wire wr_status = wr_go && (aw_addr_reg == OFS_STATUS);
    wire wr_hit    = wr_cmd || wr_bcf || wr_dest || wr_pc || wr_fbr || wr_ctrl || wr_status;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    wire [31:0] wr_val   = merge(32'h0000_0000, w_data_reg, w_strb_reg);
    wire        start    = wr_ctrl && w_strb_reg[0] && wr_val[CTRL_START_BIT];
    wire        idle     = (state_reg == ST_IDLE);
    wire        launch   = start && idle;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR_I;
            end
            if (w_fire) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA_I;
                w_strb_reg <= S_AXI_WSTRB_I;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && S_AXI_BREADY_I) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_BRESP_O  = bresp_reg;

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    wire [31:0] bcf_mrg = merge({8'h00, bcf_reg}, w_data_reg, w_strb_reg);
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cmd_reg    <= RST_CMD;
            bcf_reg    <= RST_BCF;
            dest_reg   <= RST_DEST;
            target_reg <= 1'b0;
        end else begin
            if (wr_cmd && w_strb_reg[0]) begin
                cmd_reg <= w_data_reg[7:0];
            end
            if (wr_bcf) begin
                bcf_reg <= bcf_mrg[23:0];
            end
            if (wr_dest) begin
                dest_reg <= merge(dest_reg, w_data_reg, w_strb_reg);
            end
            if (wr_ctrl && w_strb_reg[0]) begin
                target_reg <= w_data_reg[CTRL_TARGET_BIT];
            end
        end
    end

    // The data path loads the received byte; it wins over a software write.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            fbr_reg <= RST_FBR;
        end else if (FBR_LOAD_I) begin
            fbr_reg <= FBR_DATA_I;
        end else if (wr_fbr && w_strb_reg[0]) begin
            fbr_reg <= w_data_reg[7:0];
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (launch && is_jump && instr.wait_bit) begin
                    state_next = ST_WAIT;
                end else if (launch) begin
                    state_next = ST_EXEC;
                end
            end
            ST_WAIT: begin
                if (req_ready) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire exec = (state_reg == ST_EXEC);

    // The pointer already addresses the next instruction, so falling
    // through leaves it alone.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg       <= ST_IDLE;
            pc_reg          <= RST_PC;
            taken_reg       <= 1'b0;
            done_reg        <= 1'b0;
            error_reg       <= 1'b0;
            fetch_reg       <= 1'b0;
            taken_pulse_reg <= 1'b0;
        end else begin
            state_reg       <= state_next;
            fetch_reg       <= exec;
            taken_pulse_reg <= exec && is_jump && take_jump;
            if (launch) begin
                done_reg  <= 1'b0;
                taken_reg <= 1'b0;
                error_reg <= !is_jump;
            end else if (exec) begin
                done_reg  <= 1'b1;
                taken_reg <= is_jump && take_jump;
            end
            if (exec && is_jump && take_jump) begin
                pc_reg <= jump_dest;
            end else if (wr_pc && idle) begin
                pc_reg <= merge(pc_reg, w_data_reg, w_strb_reg);
            end
        end
    end

    assign PC_O    = pc_reg;
    assign FETCH_O = fetch_reg;
    assign TAKEN_O = taken_pulse_reg;
    assign BUSY_O  = !idle;

    // ---------------------------------------------------------------
    // AXI4-Lite read path
    // ---------------------------------------------------------------
    logic [31:0] status_word;
    always_comb begin
        status_word                 = 32'h0000_0000;
        status_word[STAT_BUSY_BIT]  = !idle;
        status_word[STAT_TAKEN_BIT] = taken_reg;
        status_word[STAT_DONE_BIT]  = done_reg;
        status_word[STAT_ERROR_BIT] = error_reg;
    end

    wire rd_cmd    = (S_AXI_ARADDR_I == OFS_CMD);
    wire rd_bcf    = (S_AXI_ARADDR_I == OFS_BCF);
    wire rd_dest   = (S_AXI_ARADDR_I == OFS_DEST);
    wire rd_pc     = (S_AXI_ARADDR_I == OFS_PC);
    wire rd_fbr    = (S_AXI_ARADDR_I == OFS_FBR);
    wire rd_ctrl   = (S_AXI_ARADDR_I == OFS_CTRL);
    wire rd_status = (S_AXI_ARADDR_I == OFS_STATUS);
    wire rd_hit    = rd_cmd || rd_bcf || rd_dest || rd_pc || rd_fbr || rd_ctrl || rd_status;
    wire [31:0] rd_val = rd_cmd    ? {24'h00_0000, cmd_reg}
                       : rd_bcf    ? {8'h00, bcf_reg}
                       : rd_dest   ? dest_reg
                       : rd_pc     ? pc_reg
                       : rd_fbr    ? {24'h00_0000, fbr_reg}
                       : rd_ctrl   ? {30'h0000_0000, target_reg, 1'b0}
                       : rd_status ? status_word
                       : 32'h0000_0000;

    assign S_AXI_ARREADY_O = !rvalid_reg;
    wire ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_val;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && S_AXI_RREADY_I) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_RVALID_O = rvalid_reg;
    assign S_AXI_RDATA_O  = rdata_reg;
    assign S_AXI_RRESP_O  = rresp_reg;

endmodule : scjmp_top
